// >>> rtl/rsst_pkg.sv
`default_nettype none
package rsst_pkg;
    // ----------------------------------------
    // Bus
    // ----------------------------------------
    localparam int         ADDR_W      = 8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CAUSE    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATE    = 8'h10;

    // ----------------------------------------
    // Cause register fields
    // ----------------------------------------
    localparam int         CB_BOR    = 0;
    localparam int         CB_POR    = 1;
    localparam int         CB_PD     = 2;
    localparam int         CB_WDT    = 3;
    localparam int         CB_INSTR  = 4;
    localparam int         CB_STKFUL = 5;
    localparam int         CB_STKUNF = 6;
    localparam int         CB_SOFT_BROWNOUT_ENABLE = 8;
    localparam int         CB_IRQ_PRIORITY_ENABLE   = 9;
    localparam int         NUM_FLAGS = 7;
    localparam logic [6:0] FLAGS_RST  = 7'h7C;
    localparam logic       SOFT_BROWNOUT_ENABLE_RST = 1'b1;
    localparam logic       IRQ_PRIORITY_ENABLE_RST   = 1'b0;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int         CT_WDT_EN  = 0;
    localparam int         CT_WDT_LP  = 1;
    localparam int         CT_KICK    = 2;
    localparam int         CT_PWRT_N  = 3;
    localparam int         CT_FOSC    = 4;
    localparam logic [6:0] CTRL_RST   = 7'h30;
    localparam logic [6:0] CTRL_WMASK = 7'h7B;
    localparam logic [2:0] FOSC_1MHZ  = 3'h3;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    // ----------------------------------------
    // Interrupt event bits
    // ----------------------------------------
    localparam int         NUM_EV = 8;
    localparam logic [7:0] EV_RST = 8'h01;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TCY_OSC       = 4;
    localparam int TCY_NS        = CLK_PERIOD_NS * TCY_OSC;
    localparam int OST_CYC       = 1024;
    localparam int PWRT_TYP_US   = 65000;
    localparam int PWRT_MIN_US   = 40000;
    localparam int PWRT_MAX_US   = 140000;
    localparam int PWRT_TCY      = PWRT_TYP_US * 1000 / TCY_NS;
    localparam int WDT_STD_US    = 17000;
    localparam int WDT_LP_US     = 18000;
    localparam int WDT_MIN_US    = 10000;
    localparam int WDT_STD_TCY   = WDT_STD_US * 1000 / TCY_NS;
    localparam int WDT_LP_TCY    = WDT_LP_US * 1000 / TCY_NS;
    localparam int TIOZ_NS       = 2730;
    localparam int TIOZ_CYC      = TIOZ_NS / CLK_PERIOD_NS;
    localparam int CNT_W         = 21;
    localparam int WDT_W         = 19;
    localparam logic [CNT_W-1:0] OST_LAST = 21'(OST_CYC - 1);
    localparam logic [10:0]      OST_LEN  = 11'(OST_CYC);

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_PWRT = 2'b01,
        ST_OST  = 2'b10,
        ST_RUN  = 2'b11
    } rsst_state_t;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } rsst_axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rsst_axil_rsp_t;
endpackage
`default_nettype wire

// >>> rtl/rsst_reset_ctrl.sv
// The address map and the AXI4-Lite slave port were decided locally.
`default_nettype none
// Operation
// - Tell apart eight reset sources
// - Seven low cause flags mark reset events
// - Event clears flag, software sets it again
// - Flags together identify latest reset type
// - Cause register holds priority, brown-out enables
// - Oscillator start-up counts 1024 periods
// - Power-up delay 65 ms when enabled
// - Pins float within 2.73 us
// - Watchdog 17 ms standard, 18 ms low-power
// - Instruction cycle is four oscillator periods
// - Execution restarts at address zero
// - Fast oscillator returns to 1 MHz
// - Pins return to input on reset
module rsst_reset_ctrl #(
    parameter int unsigned PWRT_TCY    = rsst_pkg::PWRT_TCY,
    parameter int unsigned WDT_STD_TCY = rsst_pkg::WDT_STD_TCY,
    parameter int unsigned WDT_LP_TCY  = rsst_pkg::WDT_LP_TCY
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst_b,
    input  wire rsst_pkg::rsst_axil_req_t axiReq,
    output var  rsst_pkg::rsst_axil_rsp_t axiRsp,
    input  wire logic                     extMclrB,
    input  wire logic                     pwrMgdMode,
    input  wire logic                     brownOutDet,
    input  wire logic                     resetInstr,
    input  wire logic                     stackFull,
    input  wire logic                     stackUnderflow,
    output var  logic                     coreRun,
    output var  logic                     pinsHiZ,
    output var  logic                     pinsInput,
    output var  logic                     pcLoad,
    output var  logic [15:0]              restartPc,
    output var  logic [2:0]               fastOscFreq,
    output var  logic                     irqPriorityEnable,
    output var  logic                     irq
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam logic [rsst_pkg::CNT_W-1:0] PWRT_LAST = rsst_pkg::CNT_W'(PWRT_TCY - 1);
    localparam logic [rsst_pkg::WDT_W-1:0] WSTD_LAST = rsst_pkg::WDT_W'(WDT_STD_TCY - 1);
    localparam logic [rsst_pkg::WDT_W-1:0] WLP_LAST  = rsst_pkg::WDT_W'(WDT_LP_TCY - 1);

    rsst_pkg::rsst_state_t          stateQ, stateD;
    logic [rsst_pkg::CNT_W-1:0]     cntQ;
    logic [rsst_pkg::WDT_W-1:0]     wdtCntQ;
    logic [1:0]                     tcyDivQ;
    logic [1:0]                     mclrSyncQ;
    logic                           mclrPrevQ, borPrevQ, pwrtArmQ;
    logic [6:0]                     flagsQ, ctrlQ;
    logic                           sborenQ;
    logic [7:0]                     irqStatQ, irqMaskQ;
    logic [10:0]                    ostLenQ;
    logic                           awRdyQ, wRdyQ, bValidQ, arRdyQ, rValidQ;
    logic [1:0]                     bRespQ, rRespQ;
    logic [31:0]                    rDataQ;
    logic [rsst_pkg::ADDR_W-1:0]    awAddrQ;
    logic [15:0]                    wDataQ;
    logic [1:0]                     wStrbQ;

    // ----------------------------------------
    // Source decode
    // ----------------------------------------
    wire instrTick = (tcyDivQ == 2'h3);
    wire mclrLowS  = ~mclrSyncQ[1];
    wire mclrEv    = mclrLowS & ~mclrPrevQ;
    wire borLive   = brownOutDet & sborenQ;
    wire borEv     = borLive & ~borPrevQ;
    wire wdtRun    = ctrlQ[rsst_pkg::CT_WDT_EN] & (stateQ == rsst_pkg::ST_RUN);
    wire [rsst_pkg::WDT_W-1:0] wdtLast = ctrlQ[rsst_pkg::CT_WDT_LP] ? WLP_LAST : WSTD_LAST;
    wire wdtEv     = wdtRun & instrTick & (wdtCntQ == wdtLast);
    wire anySrc    = mclrLowS | borLive | wdtEv | resetInstr | stackFull | stackUnderflow;
    wire [6:0] hwClr = {stackUnderflow, stackFull, resetInstr, wdtEv, mclrEv & pwrMgdMode, 1'b0, borEv};
    wire [7:0] evVec = {stackUnderflow, stackFull, resetInstr, wdtEv,
                        mclrEv & pwrMgdMode, mclrEv & ~pwrMgdMode, borEv, 1'b0};

    // ----------------------------------------
    // Register access decode
    // ----------------------------------------
    wire doWrite  = ~awRdyQ & ~wRdyQ & ~bValidQ;
    wire causeWr  = doWrite & (awAddrQ == rsst_pkg::OFF_CAUSE);
    wire ctrlWr   = doWrite & (awAddrQ == rsst_pkg::OFF_CTRL) & wStrbQ[0];
    wire statWr   = doWrite & (awAddrQ == rsst_pkg::OFF_IRQ_STAT) & wStrbQ[0];
    wire maskWr   = doWrite & (awAddrQ == rsst_pkg::OFF_IRQ_MASK) & wStrbQ[0];
    wire wrHit    = (awAddrQ == rsst_pkg::OFF_CAUSE) | (awAddrQ == rsst_pkg::OFF_CTRL)
                  | (awAddrQ == rsst_pkg::OFF_IRQ_STAT) | (awAddrQ == rsst_pkg::OFF_IRQ_MASK)
                  | (awAddrQ == rsst_pkg::OFF_STATE);
    wire kick     = ctrlWr & wDataQ[rsst_pkg::CT_KICK];
    wire [6:0] swSet = (causeWr & wStrbQ[0]) ? wDataQ[6:0] : 7'h00;
    wire [6:0] flagsD = (flagsQ | swSet) & ~hwClr;
    wire [7:0] w1c    = statWr ? wDataQ[7:0] : 8'h00;
    wire [7:0] statD  = (irqStatQ & ~w1c) | evVec;
    wire arTake   = axiReq.arvalid & arRdyQ;
    wire [rsst_pkg::ADDR_W-1:0] ra = axiReq.araddr;
    wire rdHit    = (ra == rsst_pkg::OFF_CAUSE) | (ra == rsst_pkg::OFF_CTRL) | (ra == rsst_pkg::OFF_IRQ_STAT)
                  | (ra == rsst_pkg::OFF_IRQ_MASK) | (ra == rsst_pkg::OFF_STATE);
    wire [31:0] rdWord =
        (ra == rsst_pkg::OFF_CAUSE)    ? {22'h0, irqPriorityEnable, sborenQ, 1'b0, flagsQ} :
        (ra == rsst_pkg::OFF_CTRL)     ? {25'h0, ctrlQ} :
        (ra == rsst_pkg::OFF_IRQ_STAT) ? {24'h0, irqStatQ} :
        (ra == rsst_pkg::OFF_IRQ_MASK) ? {24'h0, irqMaskQ} :
        (ra == rsst_pkg::OFF_STATE)    ? {29'h0, pinsHiZ, stateQ} : 32'h0;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        stateD = stateQ;
        case (stateQ)
            rsst_pkg::ST_HOLD: begin
                stateD = (pwrtArmQ & ~ctrlQ[rsst_pkg::CT_PWRT_N]) ? rsst_pkg::ST_PWRT : rsst_pkg::ST_OST;
            end
            rsst_pkg::ST_PWRT: begin
                if (instrTick && cntQ == PWRT_LAST) begin
                    stateD = rsst_pkg::ST_OST;
                end
            end
            rsst_pkg::ST_OST: begin
                if (cntQ == rsst_pkg::OST_LAST) begin
                    stateD = rsst_pkg::ST_RUN;
                end
            end
            rsst_pkg::ST_RUN: stateD = rsst_pkg::ST_RUN;
            default:          stateD = rsst_pkg::ST_HOLD;
        endcase
        if (anySrc) begin
            stateD = rsst_pkg::ST_HOLD;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stateQ  <= rsst_pkg::ST_HOLD;
            cntQ    <= '0;
            tcyDivQ <= 2'h0;
        end else begin
            stateQ  <= stateD;
            tcyDivQ <= tcyDivQ + 2'h1;
            if (stateD != stateQ) begin
                cntQ <= '0;
            end else if (stateQ == rsst_pkg::ST_OST || (stateQ == rsst_pkg::ST_PWRT && instrTick)) begin
                cntQ <= cntQ + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwrtArmQ <= 1'b1;
        end else if (borEv) begin
            pwrtArmQ <= 1'b1;
        end else if (stateQ == rsst_pkg::ST_RUN) begin
            pwrtArmQ <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdtCntQ <= '0;
        end else if (!wdtRun || kick || wdtEv) begin
            wdtCntQ <= '0;
        end else if (instrTick) begin
            wdtCntQ <= wdtCntQ + 1'b1;
        end
    end

    // ----------------------------------------
    // Input capture
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mclrSyncQ <= 2'b11;
            mclrPrevQ <= 1'b0;
            borPrevQ  <= 1'b0;
        end else begin
            mclrSyncQ <= {mclrSyncQ[0], extMclrB};
            mclrPrevQ <= mclrLowS;
            borPrevQ  <= borLive;
        end
    end

    // ----------------------------------------
    // Outputs to core and pins
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            coreRun     <= 1'b0;
            pinsHiZ     <= 1'b1;
            pinsInput   <= 1'b1;
            pcLoad      <= 1'b0;
            restartPc   <= rsst_pkg::RESET_VECTOR;
            fastOscFreq <= rsst_pkg::FOSC_1MHZ;
            irq         <= 1'b0;
        end else begin
            coreRun     <= (stateD == rsst_pkg::ST_RUN);
            pinsHiZ     <= (stateD != rsst_pkg::ST_RUN);
            pinsInput   <= (stateD != rsst_pkg::ST_RUN);
            pcLoad      <= (stateD == rsst_pkg::ST_RUN) & (stateQ != rsst_pkg::ST_RUN);
            restartPc   <= rsst_pkg::RESET_VECTOR;
            fastOscFreq <= (stateD != rsst_pkg::ST_RUN) ? rsst_pkg::FOSC_1MHZ : ctrlQ[6:4];
            irq         <= |(statD & irqMaskQ);
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flagsQ            <= rsst_pkg::FLAGS_RST;
            sborenQ           <= rsst_pkg::SOFT_BROWNOUT_ENABLE_RST;
            irqPriorityEnable <= rsst_pkg::IRQ_PRIORITY_ENABLE_RST;
            irqStatQ          <= rsst_pkg::EV_RST;
            irqMaskQ          <= 8'h00;
        end else begin
            flagsQ   <= flagsD;
            irqStatQ <= statD;
            if (maskWr) begin
                irqMaskQ <= wDataQ[7:0];
            end
            if (causeWr && wStrbQ[1]) begin
                sborenQ           <= wDataQ[rsst_pkg::CB_SOFT_BROWNOUT_ENABLE];
                irqPriorityEnable <= wDataQ[rsst_pkg::CB_IRQ_PRIORITY_ENABLE];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrlQ <= rsst_pkg::CTRL_RST;
        end else if (stateQ == rsst_pkg::ST_HOLD) begin
            ctrlQ[6:4] <= rsst_pkg::FOSC_1MHZ;
        end else if (ctrlWr) begin
            ctrlQ <= wDataQ[6:0] & rsst_pkg::CTRL_WMASK;
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            awRdyQ  <= 1'b1;
            wRdyQ   <= 1'b1;
            bValidQ <= 1'b0;
            bRespQ  <= rsst_pkg::RESP_OKAY;
            awAddrQ <= '0;
            wDataQ  <= 16'h0000;
            wStrbQ  <= 2'h0;
        end else begin
            if (axiReq.awvalid && awRdyQ) begin
                awRdyQ  <= 1'b0;
                awAddrQ <= axiReq.awaddr;
            end
            if (axiReq.wvalid && wRdyQ) begin
                wRdyQ  <= 1'b0;
                wDataQ <= axiReq.wdata[15:0];
                wStrbQ <= axiReq.wstrb[1:0];
            end
            if (doWrite) begin
                bValidQ <= 1'b1;
                bRespQ  <= wrHit ? rsst_pkg::RESP_OKAY : rsst_pkg::RESP_SLVERR;
            end else if (bValidQ && axiReq.bready) begin
                bValidQ <= 1'b0;
                awRdyQ  <= 1'b1;
                wRdyQ   <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            arRdyQ  <= 1'b1;
            rValidQ <= 1'b0;
            rDataQ  <= 32'h0;
            rRespQ  <= rsst_pkg::RESP_OKAY;
        end else if (arTake) begin
            arRdyQ  <= 1'b0;
            rValidQ <= 1'b1;
            rDataQ  <= rdWord;
            rRespQ  <= rdHit ? rsst_pkg::RESP_OKAY : rsst_pkg::RESP_SLVERR;
        end else if (rValidQ && axiReq.rready) begin
            rValidQ <= 1'b0;
            arRdyQ  <= 1'b1;
        end
    end

    assign axiRsp.awready = awRdyQ;
    assign axiRsp.wready  = wRdyQ;
    assign axiRsp.bvalid  = bValidQ;
    assign axiRsp.bresp   = bRespQ;
    assign axiRsp.arready = arRdyQ;
    assign axiRsp.rvalid  = rValidQ;
    assign axiRsp.rdata   = rDataQ;
    assign axiRsp.rresp   = rRespQ;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ostLenQ <= 11'h000;
        end else if (stateQ == rsst_pkg::ST_OST) begin
            ostLenQ <= ostLenQ + 11'h001;
        end else if (stateQ != rsst_pkg::ST_RUN) begin
            ostLenQ <= 11'h000;
        end
    end

    property p_pins_float;
        @(posedge core_clk) disable iff (!rst_b) (mclrLowS || wdtEv) |=> pinsHiZ && pinsInput;
    endproperty
    a_pins_float: assert property (p_pins_float) else $error("pins not floated");

    property p_ost_len;
        @(posedge core_clk) disable iff (!rst_b) $rose(coreRun) |-> ostLenQ == rsst_pkg::OST_LEN;
    endproperty
    a_ost_len: assert property (p_ost_len) else $error("start-up count wrong");

    property p_hold_reset;
        @(posedge core_clk) disable iff (!rst_b) anySrc |=> !coreRun [*8];
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("released too early");

    property p_wdt_flag;
        @(posedge core_clk) disable iff (!rst_b) wdtEv |=> !flagsQ[rsst_pkg::CB_WDT] ##1 !coreRun;
    endproperty
    a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag kept");

    property p_instr_id;
        @(posedge core_clk) disable iff (!rst_b)
        (hwClr == 7'h10 && !causeWr) |=> flagsQ == ($past(flagsQ) & 7'h6F);
    endproperty
    a_instr_id: assert property (p_instr_id) else $error("cause pattern wrong");

    property p_tcy;
        @(posedge core_clk) disable iff (!rst_b) instrTick |=> !instrTick [*3] ##1 instrTick;
    endproperty
    a_tcy: assert property (p_tcy) else $error("cycle tick wrong");

    property p_pc_zero;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(coreRun) |-> pcLoad && restartPc == rsst_pkg::RESET_VECTOR;
    endproperty
    a_pc_zero: assert property (p_pc_zero) else $error("restart address wrong");

    property p_osc_default;
        @(posedge core_clk) disable iff (!rst_b) pinsHiZ |-> fastOscFreq == rsst_pkg::FOSC_1MHZ;
    endproperty
    a_osc_default: assert property (p_osc_default) else $error("oscillator not 1 MHz");
endmodule // rsst_reset_ctrl
`default_nettype wire

// >>> bench/rsst_supply_model.sv
`default_nettype none
module rsst_supply_model (
    input  wire logic core_clk,
    input  wire logic mclrReq,
    input  wire logic pmReq,
    input  wire logic borReq,
    output var  logic extMclrB,
    output var  logic pwrMgdMode,
    output var  logic brownOutDet
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Pin and supply levels
    // ----------------------------------------
    // Master clear pin, power-managed mode and brown-out levels
    always @(posedge core_clk) begin
        extMclrB    <= !mclrReq;
        pwrMgdMode  <= pmReq;
        brownOutDet <= borReq;
    end
endmodule // rsst_supply_model
`default_nettype wire

// >>> bench/test_reset_source_and_startup_timers.sv
`default_nettype none
module test_reset_source_and_startup_timers;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PWRT = 20;
    logic                     core_clk;
    logic                     rst_b;
    rsst_pkg::rsst_axil_req_t axiReq;
    rsst_pkg::rsst_axil_rsp_t axiRsp;
    logic                     mclrReq, pmReq, borReq, extMclrB, pwrMgdMode, brownOutDet;
    logic                     resetInstr, stackFull, stackUnderflow;
    logic                     coreRun, pinsHiZ, pinsInput, pcLoad, irqPriorityEnable, irq;
    logic [15:0]              restartPc;
    logic [2:0]               fastOscFreq;
    int                       cmpCount = 0;
    int                       mismatches = 0;
    int                       evTab[7] = '{2, 3, 1, 5, 6, 7, 4};
    logic [31:0]              clrTab[7] = '{32'h0, 32'h4, 32'h1, 32'h10, 32'h20, 32'h40, 32'h8};

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = !core_clk;
    end

    rsst_supply_model sup_u (.core_clk(core_clk), .mclrReq(mclrReq), .pmReq(pmReq), .borReq(borReq),
        .extMclrB(extMclrB), .pwrMgdMode(pwrMgdMode), .brownOutDet(brownOutDet));

    rsst_reset_ctrl #(.PWRT_TCY(PWRT), .WDT_STD_TCY(40), .WDT_LP_TCY(50)) dut_u (.core_clk(core_clk),
        .rst_b(rst_b), .axiReq(axiReq), .axiRsp(axiRsp), .extMclrB(extMclrB), .pwrMgdMode(pwrMgdMode),
        .brownOutDet(brownOutDet), .resetInstr(resetInstr), .stackFull(stackFull),
        .stackUnderflow(stackUnderflow), .coreRun(coreRun), .pinsHiZ(pinsHiZ), .pinsInput(pinsInput),
        .pcLoad(pcLoad), .restartPc(restartPc), .fastOscFreq(fastOscFreq),
        .irqPriorityEnable(irqPriorityEnable), .irq(irq));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic giveVerdict();
        $display("compares %0d mismatches %0d", cmpCount, mismatches);
        if (mismatches == 0 && cmpCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge core_clk);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr  <= a;
        axiReq.wvalid  <= 1'b1;
        axiReq.wdata   <= d;
        axiReq.wstrb   <= 4'hF;
        axiReq.bready  <= 1'b1;
        while (n < 100) begin
            @(posedge core_clk);
            n++;
            if (axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
            if (axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
            if (axiRsp.bvalid === 1'b1) begin
                axiReq.bready <= 1'b0;
                chk("bresp", axiRsp.bresp, er);
                n = 1000;
            end
        end
        if (n < 1000) chk("bvalid", 0, 1);
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge core_clk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr  <= a;
        axiReq.rready  <= 1'b1;
        while (n < 100) begin
            @(posedge core_clk);
            n++;
            if (axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
            if (axiRsp.rvalid === 1'b1) begin
                axiReq.rready <= 1'b0;
                chk("rdata", axiRsp.rdata, ed);
                chk("rresp", axiRsp.rresp, er);
                n = 1000;
            end
        end
        if (n < 1000) chk("rvalid", 0, 1);
    endtask

    task automatic waitRun(input int mn, input int n);
        while (coreRun !== 1'b1 && n < mn + 16) begin
            @(posedge core_clk);
            n++;
        end
        chk("startLen", n >= mn, 1);
        chk("coreRun", coreRun, 1);
        chk("pcLoad", pcLoad, 1);
        chk("restartPc", restartPc, 16'h0000);
        chk("pinsFree", pinsHiZ, 0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic testInit();
        waitRun(1024 + 4 * PWRT, 0);
        axr(rsst_pkg::OFF_CAUSE, 32'h17C, rsst_pkg::RESP_OKAY);
        axr(rsst_pkg::OFF_CTRL, 32'h30, rsst_pkg::RESP_OKAY);
        axr(rsst_pkg::OFF_IRQ_STAT, 32'h1, rsst_pkg::RESP_OKAY);
        axr(rsst_pkg::OFF_IRQ_MASK, 32'h0, rsst_pkg::RESP_OKAY);
        axr(rsst_pkg::OFF_STATE, 32'h3, rsst_pkg::RESP_OKAY);
        axr(8'h14, 32'h0, rsst_pkg::RESP_SLVERR);
        axw(8'h14, 32'hFFFFFFFF, rsst_pkg::RESP_SLVERR);
        chk("irqMasked", irq, 0);
        axw(rsst_pkg::OFF_CAUSE, 32'h37C, rsst_pkg::RESP_OKAY);
        @(posedge core_clk);
        chk("irqPriorityEnable", irqPriorityEnable, 1);
        $display("test init done");
    endtask

    task automatic fire(input int k);
        int n;
        n = 0;
        axw(rsst_pkg::OFF_CAUSE, 32'h17F, rsst_pkg::RESP_OKAY);
        axw(rsst_pkg::OFF_IRQ_STAT, 32'hFF, rsst_pkg::RESP_OKAY);
        axw(rsst_pkg::OFF_IRQ_MASK, 32'h1 << evTab[k], rsst_pkg::RESP_OKAY);
        axw(rsst_pkg::OFF_CTRL, 32'h50 | 32'(k == 6), rsst_pkg::RESP_OKAY);
        @(posedge core_clk);
        chk("oscSel", fastOscFreq, 3'h5);
        pmReq          <= (k == 1);
        mclrReq        <= (k < 2);
        borReq         <= (k == 2);
        resetInstr     <= (k == 3);
        stackFull      <= (k == 4);
        stackUnderflow <= (k == 5);
        @(posedge core_clk);
        resetInstr     <= 1'b0;
        stackFull      <= 1'b0;
        stackUnderflow <= 1'b0;
        while (pinsHiZ !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        chk("pinsHiZ", pinsHiZ, 1);
        chk("hiZDelay", n <= rsst_pkg::TIOZ_CYC, 1);
        chk("pinsInput", pinsInput, 1);
        chk("fastOscFreq", fastOscFreq, rsst_pkg::FOSC_1MHZ);
        chk("heldRun", coreRun, 0);
        repeat (4) @(posedge core_clk);
        mclrReq <= 1'b0;
        borReq  <= 1'b0;
        waitRun(1024 + (k == 2 ? 4 * PWRT : 0), 4);
        pmReq <= 1'b0;
        axw(rsst_pkg::OFF_CTRL, 32'h30, rsst_pkg::RESP_OKAY);
        axr(rsst_pkg::OFF_CAUSE, 32'h17F & ~clrTab[k], rsst_pkg::RESP_OKAY);
        axr(rsst_pkg::OFF_IRQ_STAT, 32'h1 << evTab[k], rsst_pkg::RESP_OKAY);
        chk("irqSet", irq, 1);
        axw(rsst_pkg::OFF_IRQ_STAT, 32'h1 << evTab[k], rsst_pkg::RESP_OKAY);
        repeat (2) @(posedge core_clk);
        chk("irqClear", irq, 0);
        $display("test fire %0d done", k);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        axiReq         = '0;
        rst_b          = 1'b0;
        mclrReq        = 1'b0;
        pmReq          = 1'b0;
        borReq         = 1'b0;
        resetInstr     = 1'b0;
        stackFull      = 1'b0;
        stackUnderflow = 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        testInit();
        for (int k = 0; k < 7; k++) begin
            fire(k);
        end
        giveVerdict();
    end

    initial begin
        #500000;
        mismatches++;
        giveVerdict();
    end
endmodule // test_reset_source_and_startup_timers
`default_nettype wire
